// >>> core/fsr_defines.vh
// Constants for the flash status polling controller
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH
// Status bit positions on the data bus
`define FSR_BIT_POLL 7
`define FSR_BIT_TOGGLE 6
`define FSR_BIT_FAIL 5
`define FSR_BIT_WINDOW 3
`define FSR_BIT_SECTOR 2
// Reset command data
`define FSR_RESET_CMD 16'h00f0
// Read and write strobe timing at 100 MHz (ns, cycles)
`define FSR_CLK_NS 10
`define FSR_ACCESS_NS 120
`define FSR_ACCESS_CYC ((`FSR_ACCESS_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_WE_NS 60
`define FSR_WE_CYC ((`FSR_WE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_RECOVER_CYC 2
// Sector erase acceptance window, longest spacing (us, cycles)
`define FSR_WINDOW_US 50
`define FSR_WINDOW_CYC ((`FSR_WINDOW_US * 1000) / `FSR_CLK_NS)
// Counter width for strobe timing
`define FSR_CNT_W 8
`endif

// >>> core/fsr_strobe.v
// Single flash bus cycle engine: one read or one write
`default_nettype none
`include "fsr_defines.vh"
module fsr_strobe (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Request from sequencer
  input wire start,
  input wire is_write,
  input wire [21:0] addr,
  input wire [15:0] wdata,
  output wire busy,
  output reg done,
  output reg [15:0] rdata_reg,
  // Flash pins
  output reg [21:0] fl_addr_reg,
  output reg fl_ce_n_reg,
  output reg fl_oe_n_reg,
  output reg fl_we_n_reg,
  output reg [15:0] fl_dq_out_reg,
  output reg fl_dq_oe_reg,
  input wire [15:0] fl_dq_in
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ACT = 2'd1;
  localparam [1:0] ST_REC = 2'd2;
  // Loads kept as 32-bit words and cut to the counter width on use
  localparam [31:0] WE_LOAD = `FSR_WE_CYC;
  // Extra two cycles cover the input synchroniser latency
  localparam [31:0] RD_LOAD = `FSR_ACCESS_CYC + 2;
  localparam [31:0] REC_LOAD = `FSR_RECOVER_CYC;
  // Decrement step at counter width
  localparam [`FSR_CNT_W-1:0] CNT_ONE = {{(`FSR_CNT_W-1){1'b0}}, 1'b1};
  // Sampled data bus; two stages since the pins are asynchronous
  reg [15:0] dq_meta_reg;
  reg [15:0] dq_sync_reg;
  reg [1:0] state_reg;
  reg [`FSR_CNT_W-1:0] cnt_reg;
  reg wr_reg;
  assign busy = (state_reg != ST_IDLE);
  // Two flops before anything reads the data bus
  always @(posedge core_clk) begin
    dq_meta_reg <= fl_dq_in;
    dq_sync_reg <= dq_meta_reg;
  end
  // Strobe sequencer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`FSR_CNT_W{1'b0}};
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata_reg <= 16'h0000;
      fl_addr_reg <= 22'h000000;
      fl_ce_n_reg <= 1'b1;
      fl_oe_n_reg <= 1'b1;
      fl_we_n_reg <= 1'b1;
      fl_dq_out_reg <= 16'h0000;
      fl_dq_oe_reg <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // Each read is a full CE/OE cycle so status bits toggle
            state_reg <= ST_ACT;
            wr_reg <= is_write;
            fl_addr_reg <= addr;
            fl_ce_n_reg <= 1'b0;
            fl_oe_n_reg <= is_write;
            fl_we_n_reg <= ~is_write;
            fl_dq_out_reg <= wdata;
            fl_dq_oe_reg <= is_write;
            // Write strobe width, or read access plus sync latency
            cnt_reg <= is_write ? WE_LOAD[`FSR_CNT_W-1:0]
                                : RD_LOAD[`FSR_CNT_W-1:0];
          end
        end
        ST_ACT: begin
          if (cnt_reg == {`FSR_CNT_W{1'b0}}) begin
            state_reg <= ST_REC;
            cnt_reg <= REC_LOAD[`FSR_CNT_W-1:0];
            if (!wr_reg) begin
              rdata_reg <= dq_sync_reg;
            end
            fl_ce_n_reg <= 1'b1;
            fl_oe_n_reg <= 1'b1;
            fl_we_n_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        ST_REC: begin
          // Data held past WE rise, then bus released
          fl_dq_oe_reg <= 1'b0;
          if (cnt_reg == {`FSR_CNT_W{1'b0}}) begin
            state_reg <= ST_IDLE;
            done <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fsr_strobe
`default_nettype wire

// >>> core/fsr_poll_ctrl.v
// Host-side flash status poller: toggle and window checks
`default_nettype none
`include "fsr_defines.vh"
// Contract
// - Host reads status twice, compares toggle
// - Toggle steady means done; array data next
// - Toggling with failure: recheck, else failed
// - Resumed polling restarts the two-read check
// - Host issues reset after any failure
// - Extra sectors within 50 us skip window
// - Window checked before and after sector command
// - Status reads use a valid address
module fsr_poll_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // User orders
  input wire cmd_poll,
  input wire cmd_sector,
  input wire cmd_abort,
  input wire [21:0] cmd_addr,
  input wire [15:0] cmd_data,
  input wire cmd_trust_window,
  output wire cmd_ready,
  // User results
  output reg res_valid_reg,
  output reg res_pass_reg,
  output reg res_fail_reg,
  output reg res_rejected_reg,
  output reg [15:0] res_data_reg,
  output reg ready_seen_reg,
  // Flash pins
  output wire [21:0] fl_addr,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n,
  output wire [15:0] fl_dq_out,
  output wire fl_dq_oe,
  input wire [15:0] fl_dq_in,
  input wire ready_busy_output
);
  localparam [3:0] ST_IDLE = 4'd0;
  localparam [3:0] ST_RD1 = 4'd1;
  localparam [3:0] ST_RD2 = 4'd2;
  localparam [3:0] ST_RECHK = 4'd3;
  localparam [3:0] ST_ARRAY = 4'd4;
  localparam [3:0] ST_RESET = 4'd5;
  localparam [3:0] ST_WPRE = 4'd6;
  localparam [3:0] ST_WCMD = 4'd7;
  localparam [3:0] ST_WPOST = 4'd8;
  reg [3:0] state_reg;
  reg [21:0] addr_reg;
  reg [15:0] data_reg;
  reg first_tog_reg; // Toggle value from previous read
  reg fail_path_reg; // Failure bit seen high this check
  reg skip_reg; // Window checks skipped by user
  reg rb_meta_reg;
  reg rb_sync_reg;
  reg st_start;
  reg st_write;
  reg [15:0] st_wdata;
  reg [21:0] st_addr;
  wire st_busy;
  wire st_done;
  wire [15:0] st_rdata;
  // Toggle compare used on two states, ST_RD2 and ST_RECHK
  function toggled;
    input [15:0] now;
    input prev;
    begin
      toggled = now[`FSR_BIT_TOGGLE] ^ prev;
    end
  endfunction
  assign cmd_ready = (state_reg == ST_IDLE) && !st_busy;
  // Ready/busy pin is asynchronous; two flops
  always @(posedge core_clk) begin
    rb_meta_reg <= ready_busy_output;
    rb_sync_reg <= rb_meta_reg;
  end
  // Bus cycle engine
  fsr_strobe u_strobe (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(st_start),
    .is_write(st_write),
    .addr(st_addr),
    .wdata(st_wdata),
    .busy(st_busy),
    .done(st_done),
    .rdata_reg(st_rdata),
    .fl_addr_reg(fl_addr),
    .fl_ce_n_reg(fl_ce_n),
    .fl_oe_n_reg(fl_oe_n),
    .fl_we_n_reg(fl_we_n),
    .fl_dq_out_reg(fl_dq_out),
    .fl_dq_oe_reg(fl_dq_oe),
    .fl_dq_in(fl_dq_in)
  );
  // Launch one bus cycle on state entry while engine is idle
  always @* begin
    st_start = 1'b0;
    st_write = 1'b0;
    st_wdata = data_reg;
    st_addr = addr_reg;
    if (!st_busy && !st_done) begin
      case (state_reg)
        ST_RD1, ST_RD2, ST_RECHK, ST_ARRAY, ST_WPRE, ST_WPOST: begin
          st_start = 1'b1;
        end
        ST_RESET: begin
          st_start = 1'b1;
          st_write = 1'b1;
          st_wdata = `FSR_RESET_CMD;
        end
        ST_WCMD: begin
          st_start = 1'b1;
          st_write = 1'b1;
        end
        default: begin
          st_start = 1'b0;
        end
      endcase
    end
  end
  // Polling sequencer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      addr_reg <= 22'h000000;
      data_reg <= 16'h0000;
      first_tog_reg <= 1'b0;
      fail_path_reg <= 1'b0;
      skip_reg <= 1'b0;
      res_valid_reg <= 1'b0;
      res_pass_reg <= 1'b0;
      res_fail_reg <= 1'b0;
      res_rejected_reg <= 1'b0;
      res_data_reg <= 16'h0000;
      ready_seen_reg <= 1'b0;
    end else begin
      res_valid_reg <= 1'b0;
      ready_seen_reg <= rb_sync_reg;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_ready && cmd_poll) begin
            addr_reg <= cmd_addr;
            fail_path_reg <= 1'b0;
            state_reg <= ST_RD1;
          end else if (cmd_ready && cmd_sector) begin
            addr_reg <= cmd_addr;
            data_reg <= cmd_data;
            skip_reg <= cmd_trust_window;
            state_reg <= cmd_trust_window ? ST_WCMD : ST_WPRE;
          end
        end
        ST_RD1: begin
          if (st_done) begin
            first_tog_reg <= st_rdata[`FSR_BIT_TOGGLE];
            state_reg <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (st_done) begin
            first_tog_reg <= st_rdata[`FSR_BIT_TOGGLE];
            if (!toggled(st_rdata, first_tog_reg)) begin
              state_reg <= ST_ARRAY;
            end else if (st_rdata[`FSR_BIT_FAIL]) begin
              fail_path_reg <= 1'b1;
              state_reg <= ST_RECHK;
            end else if (cmd_abort) begin
              // User leaves polling; next poll restarts
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_RD2;
            end
          end
        end
        ST_RECHK: begin
          if (st_done) begin
            if (!toggled(st_rdata, first_tog_reg)) begin
              state_reg <= ST_ARRAY;
            end else begin
              state_reg <= ST_RESET;
            end
          end
        end
        ST_ARRAY: begin
          if (st_done) begin
            res_valid_reg <= 1'b1;
            res_pass_reg <= 1'b1;
            res_fail_reg <= 1'b0;
            res_rejected_reg <= 1'b0;
            res_data_reg <= st_rdata;
            state_reg <= ST_IDLE;
          end
        end
        ST_RESET: begin
          if (st_done) begin
            res_valid_reg <= 1'b1;
            res_pass_reg <= 1'b0;
            res_fail_reg <= 1'b1;
            res_rejected_reg <= 1'b0;
            res_data_reg <= 16'h0000;
            state_reg <= ST_IDLE;
          end
        end
        ST_WPRE: begin
          if (st_done) begin
            if (st_rdata[`FSR_BIT_WINDOW]) begin
              res_valid_reg <= 1'b1;
              res_pass_reg <= 1'b0;
              res_fail_reg <= 1'b0;
              res_rejected_reg <= 1'b1;
              res_data_reg <= st_rdata;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_WCMD;
            end
          end
        end
        ST_WCMD: begin
          if (st_done) begin
            state_reg <= skip_reg ? ST_IDLE : ST_WPOST;
            if (skip_reg) begin
              res_valid_reg <= 1'b1;
              res_pass_reg <= 1'b1;
              res_fail_reg <= 1'b0;
              res_rejected_reg <= 1'b0;
            end
          end
        end
        ST_WPOST: begin
          if (st_done) begin
            // window one after: may be rejected
            res_valid_reg <= 1'b1;
            res_pass_reg <= ~st_rdata[`FSR_BIT_WINDOW];
            res_fail_reg <= 1'b0;
            res_rejected_reg <= st_rdata[`FSR_BIT_WINDOW];
            res_data_reg <= st_rdata;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fsr_poll_ctrl
`default_nettype wire

// >>> verification/fsr_poll_sva.sv
// Checker of the flash poller pin and result timing
`default_nettype none
module fsr_poll_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // User side
  input wire logic cmd_poll,
  input wire logic cmd_sector,
  input wire logic cmd_ready,
  input wire logic [21:0] cmd_addr,
  input wire logic res_valid_reg,
  input wire logic res_pass_reg,
  input wire logic res_fail_reg,
  // Flash pins
  input wire logic [21:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Address of the order in flight
  logic [21:0] addr_q;
  // Latched at take, so reads can be tied to it
  always @(posedge core_clk)
    if (cmd_ready && (cmd_poll || cmd_sector)) addr_q <= cmd_addr;
  // Read and write strobe phases
  sequence s_read; (!fl_oe_n && !fl_ce_n)[*8]; endsequence
  sequence s_write; (!fl_we_n && fl_dq_oe)[*6]; endsequence
  a_read_held: assert property ($fell(fl_oe_n) |-> s_read)
    else $error("read strobe too short");
  a_write_driven: assert property ($fell(fl_we_n) |-> s_write)
    else $error("write strobe too short");
  a_poll_addr: assert property (!fl_oe_n |-> fl_addr == addr_q)
    else $error("status read at wrong address");
  a_no_clash: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe)
    else $error("bus driven during read");
  a_idle_pins: assert property (cmd_ready |-> fl_ce_n && fl_we_n)
    else $error("pins active while idle");
  a_result_pulse: assert property (res_valid_reg |=> !res_valid_reg)
    else $error("result pulse too long");
  a_one_verdict: assert property (
    res_valid_reg |-> !(res_pass_reg && res_fail_reg))
    else $error("pass and fail together");
  a_addr_stable: assert property (
    (!fl_ce_n && $past(!fl_ce_n)) |-> $stable(fl_addr))
    else $error("address moved in cycle");
  a_take_busy: assert property (cmd_ready && cmd_poll |=> !cmd_ready)
    else $error("poll not taken");
endmodule // fsr_poll_sva
bind fsr_poll_ctrl fsr_poll_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .cmd_poll(cmd_poll), .cmd_sector(cmd_sector), .cmd_ready(cmd_ready),
  .cmd_addr(cmd_addr), .res_valid_reg(res_valid_reg),
  .res_pass_reg(res_pass_reg), .res_fail_reg(res_fail_reg),
  .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .fl_dq_oe(fl_dq_oe));
`default_nettype wire

// >>> verification/fsr_flash_model.sv
// Behavioural flash device answering status reads
`default_nettype none
`include "fsr_defines.vh"
module fsr_flash_model #(parameter int WIN_NS = 3000) (
  // Flash pins
  input wire logic [21:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe,
  output logic [15:0] fl_dq_in,
  output logic ready_busy_output
);
  timeunit 1ns;
  timeprecision 1ps;
  // Operation state; counters are read by the bench
  logic busy = 0, erase = 0, tog = 0;
  int left = 0, fail_at = 0, rd_op = 0;
  int n_rd = 0, n_wr = 0, n_rst = 0, n_acc = 0;
  logic [15:0] arr = 16'h5a3c, last = 16'h0000;
  realtime win_t = 0;
  // Start an operation; left 0 means it never ends by itself
  task automatic start_op(input int l, input int f, input logic e);
    left = l;
    fail_at = f;
    erase = e;
    rd_op = 0;
    tog = 0;
    busy = 1;
    win_t = $realtime;
  endtask
  // Status word seen while an algorithm runs
  function automatic logic [15:0] stat();
    logic [15:0] s;
    s = arr;
    s[7] = erase ? 1'b0 : ~arr[7];
    s[6] = tog;
    s[2] = erase ? tog : arr[2];
    s[5] = rd_op >= fail_at;
    s[3] = erase && ($realtime - win_t > WIN_NS);
    return s;
  endfunction
  initial fl_dq_in = 16'hffff;
  // Released bus shows inverted last word, never a stale copy
  always @(fl_ce_n or fl_oe_n) begin
    if (!fl_ce_n && !fl_oe_n) last = busy ? stat() : arr;
    fl_dq_in = (!fl_ce_n && !fl_oe_n) ? last : ~last;
  end
  always @(posedge fl_oe_n) begin
    n_rd++;
    if (busy) begin
      tog = ~tog;
      rd_op++;
      if (left != 0 && rd_op >= left) busy = 0;
    end
  end
  always @(posedge fl_we_n) begin
    n_wr++;
    if (fl_dq_out === `FSR_RESET_CMD) begin
      busy = 0;
      n_rst++;
    end else if (busy && erase && $realtime - win_t <= WIN_NS) begin
      win_t = $realtime;
      n_acc++;
    end
  end
  assign ready_busy_output = ~busy;
endmodule // fsr_flash_model
`default_nettype wire

// >>> verification/tb.sv
// Testbench for the flash status poller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, cmd_poll, cmd_sector, cmd_abort, cmd_trust_window;
  logic [21:0] cmd_addr;
  logic [15:0] cmd_data, res_data_reg, fl_dq_out, fl_dq_in;
  logic [21:0] fl_addr;
  logic cmd_ready, res_valid_reg, res_pass_reg, res_fail_reg;
  logic res_rejected_reg, ready_seen_reg, fl_ce_n, fl_oe_n, fl_we_n;
  logic fl_dq_oe, ready_busy_output, got;
  int n_fail = 0, n_checks = 0, n0, w0;
  fsr_poll_ctrl uut (.core_clk(core_clk), .rst_n(rst_n),
    .cmd_poll(cmd_poll), .cmd_sector(cmd_sector), .cmd_abort(cmd_abort),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_trust_window(cmd_trust_window), .cmd_ready(cmd_ready),
    .res_valid_reg(res_valid_reg), .res_pass_reg(res_pass_reg),
    .res_fail_reg(res_fail_reg), .res_rejected_reg(res_rejected_reg),
    .res_data_reg(res_data_reg), .ready_seen_reg(ready_seen_reg),
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(fl_dq_in), .ready_busy_output(ready_busy_output));
  fsr_flash_model m (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
    .ready_busy_output(ready_busy_output));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hand one order over once the poller is idle
  task order(input logic p, input logic s, input logic t);
    for (int i = 0; i < 5000 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
    cmd_poll = p;
    cmd_sector = s;
    cmd_trust_window = t;
    @(negedge core_clk);
    cmd_poll = 0;
    cmd_sector = 0;
  endtask
  // Bounded wait for the result pulse, or for idle with stop_on_idle
  task wait_res(input logic stop_on_idle);
    got = 0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (res_valid_reg === 1'b1) got = 1;
      if (got || (stop_on_idle && cmd_ready === 1'b1)) break;
    end
  endtask
  task poll(input int l, input int f);
    m.start_op(l, f, 0);
    n0 = m.n_rd;
    order(1, 0, 0);
    wait_res(0);
    check(got, 1);
  endtask
  task t_pass;
    poll(4, 1000);
    check(res_pass_reg, 1);
    check(res_data_reg, 16'h5a3c);
    check(m.n_rd - n0 >= 6, 1);
    check(ready_seen_reg, 1);
  endtask
  task t_fail;
    w0 = m.n_rst;
    poll(0, 3);
    check(res_fail_reg, 1);
    check(m.n_rst - w0, 1);
  endtask
  // Failure bit rises as toggling stops: recheck must pass
  task t_late;
    poll(5, 4);
    check(res_pass_reg, 1);
  endtask
  task t_abort;
    m.start_op(0, 1000, 0);
    cmd_abort = 1;
    order(1, 0, 0);
    repeat (6) @(negedge core_clk);
    check(ready_seen_reg, 0);
    wait_res(1);
    check(got, 0);
    cmd_abort = 0;
    m.left = m.rd_op + 1;
    n0 = m.n_rd;
    order(1, 0, 0);
    wait_res(0);
    check(res_pass_reg, 1);
    check(m.n_rd - n0 >= 3, 1);
  endtask
  task t_sector;
    m.start_op(0, 1000, 1);
    w0 = m.n_acc;
    order(0, 1, 0);
    wait_res(0);
    check(res_rejected_reg, 0);
    check(res_pass_reg, 1);
    check(m.n_acc - w0, 1);
    repeat (400) @(negedge core_clk);
    w0 = m.n_wr;
    order(0, 1, 0);
    wait_res(0);
    check(res_rejected_reg, 1);
    check(m.n_wr - w0, 0);
    n0 = m.n_rd;
    order(0, 1, 1);
    wait_res(1);
    check(m.n_wr - w0, 1);
    check(m.n_rd - n0, 0);
    // Window closes between pre-read and write: post-read flags it
    m.win_t = $realtime - (m.WIN_NS - 100);
    w0 = m.n_wr;
    n0 = m.n_acc;
    order(0, 1, 0);
    wait_res(0);
    check(res_rejected_reg, 1);
    check(m.n_wr - w0, 1);
    check(m.n_acc - n0, 0);
  endtask
  initial begin
    #400000;
    n_fail++;
    results;
  end
  initial begin
    rst_n = 0;
    cmd_poll = 0;
    cmd_sector = 0;
    cmd_abort = 0;
    cmd_trust_window = 0;
    cmd_addr = 22'h000100;
    cmd_data = 16'h0030;
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    @(negedge core_clk);
    t_pass;
    t_fail;
    t_late;
    t_abort;
    t_sector;
    results;
  end
endmodule // tb
`default_nettype wire
